// >>> hw/fsp_pkg.sv
package fsp_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h00;
  localparam logic [7:0] OFS_ADDR_LOW  = 8'h04;
  localparam logic [7:0] OFS_DATA_LOW  = 8'h08;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h0C;
  localparam logic [7:0] OFS_MEM_CTRL  = 8'h10;
  localparam logic [7:0] OFS_UNLOCK    = 8'h14;
  localparam logic [7:0] OFS_PROT_CFG  = 8'h18;

  // mem_control_reg field positions
  localparam int CTL_RD        = 0;
  localparam int CTL_WR        = 1;
  localparam int CTL_WEN       = 2;
  localparam int CTL_FREE      = 4;
  localparam int CTL_LOAD_ONLY = 5;
  localparam int CTL_CFG_SEL   = 6;
  localparam int CTL_PGD       = 7;

  // protection config register field positions
  localparam int PRT_WP_LO = 0;
  localparam int PRT_WP_HI = 1;
  localparam int PRT_CPROT = 2;

  // reset values
  localparam logic [1:0]  WPROT_RESET  = 2'h3;
  localparam logic        CPROT_RESET  = 1'b1;
  localparam logic [13:0] LATCH_ERASED = 14'h3FFF;

  // top address of each protected segment, by protection code
  localparam logic [13:0] PROT_TOP_CODE2 = 14'h01FF;
  localparam logic [13:0] PROT_TOP_CODE1 = 14'h0FFF;
  localparam logic [13:0] PROT_TOP_CODE0 = 14'h1FFF;
  localparam logic [1:0]  WPROT_NONE  = 2'h3;
  localparam logic [1:0]  WPROT_CODE2 = 2'h2;
  localparam logic [1:0]  WPROT_CODE1 = 2'h1;

  // unlock keys
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;

  // latch block
  localparam int NUM_LATCHES = 32;
  localparam int WORD_W      = 14;

  // timing
  localparam int SETUP_CYCLES  = 2;
  localparam int CLK_FREQ_MHZ  = 25;
  localparam int ERASE_TIME_US = 2000;
  localparam int PROG_TIME_US  = 2000;
  localparam int ERASE_CYCLES  = ERASE_TIME_US * CLK_FREQ_MHZ;
  localparam int PROG_CYCLES   = PROG_TIME_US * CLK_FREQ_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RD1   = 3'b001,
    ST_RD2   = 3'b010,
    ST_SETUP = 3'b011,
    ST_ERASE = 3'b100,
    ST_WALK  = 3'b101,
    ST_WAIT  = 3'b110
  } fsp_state_t;

  typedef enum logic [1:0] {
    UL_NONE = 2'b00,
    UL_KEY1 = 2'b01,
    UL_ARMED = 2'b10
  } fsp_unlock_t;

endpackage

// >>> hw/fsp_latch_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fsp_latch_if #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 14
);
  logic                     wr_en;
  logic [$clog2(DEPTH)-1:0] wr_idx;
  logic [WIDTH-1:0]         wr_data;
  logic [$clog2(DEPTH)-1:0] rd_idx;
  logic [WIDTH-1:0]         rd_data;

  modport ctrl (output wr_en, output wr_idx, output wr_data,
                output rd_idx, input rd_data);
  modport mem  (input wr_en, input wr_idx, input wr_data,
                input rd_idx, output rd_data);
endinterface
`default_nettype wire

// >>> hw/fsp_latch_mem.sv
`timescale 1ns/10ps
`default_nettype none
module fsp_latch_mem #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 14
) (
  input wire logic   hclk,
  input wire logic   hresetn,
  fsp_latch_if.mem   lat
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // write latches, all-ones after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= fsp_pkg::LATCH_ERASED;
      end
    end else if (lat.wr_en) begin
      mem_q[lat.wr_idx] <= lat.wr_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lat.rd_data <= fsp_pkg::LATCH_ERASED;
    end else begin
      lat.rd_data <= mem_q[lat.rd_idx];
    end
  end
endmodule // fsp_latch_mem
`default_nettype wire

// >>> hw/fsp_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - flash read steals the second cycle after the read strobe
// - read data lands in data pair next cycle and holds
// - self-reads work whatever the code-protect setting
// - erase is row-only, needs program select, erase select, write enable
// - erase or write starts only after 55h, AAh, then write strobe
// - erase select bit clears when the row erase finishes
// - two set-up cycles after the write strobe for an erase
// - core stalls for the erase time, clocks keep running
// - execution resumes at third instruction after the strobe
// - program write never erases anything itself
// - one write commits the aligned 32-latch block, never crossing it
// - every latch returns to 3FFF after a program write
// - latch-load-only strobe just copies data into addressed latch
// - latch loads do not stall the core
// - commit strobe loads last latch then programs whole block
// - two set-up cycles after the write strobe for a write
// - core stalls only during the commit, for the program time
// - write strobe cannot be set unless write enable already set
// - strobes are set-only; hardware clears them at completion
// - erase or write only outside the write-protected segment
module fsp_sequencer #(
  parameter int unsigned ERASE_CYCLES = fsp_pkg::ERASE_CYCLES,
  parameter int unsigned PROG_CYCLES  = fsp_pkg::PROG_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             cpu_stall,
  output logic [13:0]      flash_addr,
  output logic             flash_rd,
  input  wire logic [13:0] flash_rdata,
  output logic             flash_erase,
  output logic             flash_prog,
  output logic [13:0]      flash_wdata
);
  localparam int IW = $clog2(fsp_pkg::NUM_LATCHES);

  fsp_latch_if #(.DEPTH(fsp_pkg::NUM_LATCHES), .WIDTH(fsp_pkg::WORD_W)) lat ();

  fsp_latch_mem #(.DEPTH(fsp_pkg::NUM_LATCHES), .WIDTH(fsp_pkg::WORD_W))
    u_latches (
      .hclk    (hclk),
      .hresetn (hresetn),
      .lat     (lat)
    );

  logic [5:0]          addr_high_q;
  logic [7:0]          addr_low_q;
  logic [7:0]          data_low_q;
  logic [5:0]          data_high_q;
  logic                rd_q;
  logic                wr_q;
  logic                wen_q;
  logic                free_q;
  logic                load_only_q;
  logic                cfg_sel_q;
  logic                pgd_q;
  logic [1:0]          wprot_q;
  logic                cprot_q;
  fsp_pkg::fsp_unlock_t unlock_q;
  fsp_pkg::fsp_state_t  state_q;
  logic [31:0]         cnt_q;
  logic [IW:0]         idx_q;
  logic                wpend_q;
  logic                rpend_q;
  logic [7:0]          ofs_q;

  logic                acc;
  logic                wsel_ctrl;
  logic                prot_hit;
  logic                wr_req;
  logic                rd_req;
  logic                idle;
  logic [13:0]         target;
  logic [31:0]         rd_mux;
  logic [7:0]          ctrl_rd;

  assign acc       = hsel && htrans[1] && hready;
  assign idle      = (state_q == fsp_pkg::ST_IDLE);
  assign target    = {addr_high_q, addr_low_q};
  assign wsel_ctrl = wpend_q && (ofs_q == fsp_pkg::OFS_MEM_CTRL);

  // write-protected segment check
  always_comb begin
    case (wprot_q)
      fsp_pkg::WPROT_NONE:  prot_hit = 1'b0;
      fsp_pkg::WPROT_CODE2: prot_hit = (target <= fsp_pkg::PROT_TOP_CODE2);
      fsp_pkg::WPROT_CODE1: prot_hit = (target <= fsp_pkg::PROT_TOP_CODE1);
      default:              prot_hit = (target <= fsp_pkg::PROT_TOP_CODE0);
    endcase
  end

  // strobe acceptance
  assign wr_req = wsel_ctrl && hwdata[fsp_pkg::CTL_WR] && idle && !wr_q
                  && (unlock_q == fsp_pkg::UL_ARMED)
                  && wen_q
                  && pgd_q && !cfg_sel_q
                  && !prot_hit;
  // code protect is not consulted for reads
  assign rd_req = wsel_ctrl && hwdata[fsp_pkg::CTL_RD] && idle && !rd_q
                  && !wr_req;

  // ahb-lite address and data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wpend_q <= 1'b0;
      rpend_q <= 1'b0;
      ofs_q   <= 8'h00;
    end else begin
      wpend_q <= acc && hwrite;
      rpend_q <= acc && !hwrite;
      if (acc) begin
        ofs_q <= haddr[7:0];
      end
    end
  end

  // read data mux
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[fsp_pkg::CTL_RD]   = rd_q;
    ctrl_rd[fsp_pkg::CTL_WR]   = wr_q;
    ctrl_rd[fsp_pkg::CTL_WEN]       = wen_q;
    ctrl_rd[fsp_pkg::CTL_FREE]      = free_q;
    ctrl_rd[fsp_pkg::CTL_LOAD_ONLY] = load_only_q;
    ctrl_rd[fsp_pkg::CTL_CFG_SEL]   = cfg_sel_q;
    ctrl_rd[fsp_pkg::CTL_PGD]  = pgd_q;
    case (ofs_q)
      fsp_pkg::OFS_ADDR_HIGH: rd_mux = {26'h000_0000, addr_high_q};
      fsp_pkg::OFS_ADDR_LOW:  rd_mux = {24'h00_0000, addr_low_q};
      fsp_pkg::OFS_DATA_LOW:  rd_mux = {24'h00_0000, data_low_q};
      fsp_pkg::OFS_DATA_HIGH: rd_mux = {26'h000_0000, data_high_q};
      fsp_pkg::OFS_MEM_CTRL:  rd_mux = {24'h00_0000, ctrl_rd};
      fsp_pkg::OFS_PROT_CFG:  rd_mux = {29'h0000_0000, cprot_q, wprot_q};
      default:                rd_mux = 32'h0000_0000;
    endcase
  end

  // reads take one wait state so a preceding write is always visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (acc && !hwrite) begin
        hreadyout <= 1'b0;
      end else begin
        hreadyout <= 1'b1;
      end
      if (rpend_q) begin
        hrdata <= rd_mux;
      end
    end
  end

  // unlock sequence detector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unlock_q <= fsp_pkg::UL_NONE;
    end else if (wpend_q) begin
      if (ofs_q == fsp_pkg::OFS_UNLOCK
          && hwdata[7:0] == fsp_pkg::UNLOCK_KEY1) begin
        unlock_q <= fsp_pkg::UL_KEY1;
      end else if (ofs_q == fsp_pkg::OFS_UNLOCK
                   && hwdata[7:0] == fsp_pkg::UNLOCK_KEY2
                   && unlock_q == fsp_pkg::UL_KEY1) begin
        unlock_q <= fsp_pkg::UL_ARMED;
      end else begin
        unlock_q <= fsp_pkg::UL_NONE;
      end
    end
  end

  // address pair
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_high_q <= 6'h00;
      addr_low_q  <= 8'h00;
    end else if (wpend_q) begin
      if (ofs_q == fsp_pkg::OFS_ADDR_HIGH) begin
        addr_high_q <= hwdata[5:0];
      end
      if (ofs_q == fsp_pkg::OFS_ADDR_LOW) begin
        addr_low_q <= hwdata[7:0];
      end
    end
  end

  // data pair: read capture wins over a simultaneous software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_low_q  <= 8'h00;
      data_high_q <= 6'h00;
    end else if (state_q == fsp_pkg::ST_RD2) begin
      data_low_q  <= flash_rdata[7:0];
      data_high_q <= flash_rdata[13:8];
    end else if (wpend_q) begin
      if (ofs_q == fsp_pkg::OFS_DATA_LOW) begin
        data_low_q <= hwdata[7:0];
      end
      if (ofs_q == fsp_pkg::OFS_DATA_HIGH) begin
        data_high_q <= hwdata[5:0];
      end
    end
  end

  // protection configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wprot_q <= fsp_pkg::WPROT_RESET;
      cprot_q <= fsp_pkg::CPROT_RESET;
    end else if (wpend_q && ofs_q == fsp_pkg::OFS_PROT_CFG) begin
      wprot_q <= hwdata[fsp_pkg::PRT_WP_HI:fsp_pkg::PRT_WP_LO];
      cprot_q <= hwdata[fsp_pkg::PRT_CPROT];
    end
  end

  // mode bits; frozen while an operation runs, except write enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wen_q       <= 1'b0;
      free_q      <= 1'b0;
      load_only_q <= 1'b0;
      cfg_sel_q   <= 1'b0;
      pgd_q       <= 1'b0;
    end else begin
      if (wsel_ctrl) begin
        wen_q <= hwdata[fsp_pkg::CTL_WEN];
      end
      if (state_q == fsp_pkg::ST_ERASE && cnt_q == 32'h0000_0000) begin
        free_q <= 1'b0;
      end else if (wsel_ctrl && idle && !wr_q) begin
        free_q <= hwdata[fsp_pkg::CTL_FREE];
      end
      if (wsel_ctrl && idle && !wr_q && !rd_q) begin
        load_only_q <= hwdata[fsp_pkg::CTL_LOAD_ONLY];
        cfg_sel_q   <= hwdata[fsp_pkg::CTL_CFG_SEL];
        pgd_q       <= hwdata[fsp_pkg::CTL_PGD];
      end
    end
  end

  // latch port: load addressed latch on strobe, reset latches on walk
  always_comb begin
    lat.wr_en   = 1'b0;
    lat.wr_idx  = addr_low_q[IW-1:0];
    lat.wr_data = {data_high_q, data_low_q};
    lat.rd_idx  = idx_q[IW-1:0];
    if (idle && wr_req && !free_q) begin
      lat.wr_en = 1'b1;
    end else if (state_q == fsp_pkg::ST_WALK && idx_q != '0) begin
      lat.wr_en   = 1'b1;
      lat.wr_idx  = IW'(idx_q - 1'b1);
      lat.wr_data = fsp_pkg::LATCH_ERASED;
    end
  end

  // sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q     <= fsp_pkg::ST_IDLE;
      rd_q        <= 1'b0;
      wr_q        <= 1'b0;
      cnt_q       <= 32'h0000_0000;
      idx_q       <= '0;
      cpu_stall   <= 1'b0;
      flash_addr  <= 14'h0000;
      flash_rd    <= 1'b0;
      flash_erase <= 1'b0;
      flash_prog  <= 1'b0;
      flash_wdata <= fsp_pkg::LATCH_ERASED;
    end else begin
      flash_rd    <= 1'b0;
      flash_erase <= 1'b0;
      flash_prog  <= 1'b0;
      case (state_q)
        fsp_pkg::ST_IDLE: begin
          if (wr_req) begin
            wr_q    <= 1'b1;
            cnt_q   <= 32'(fsp_pkg::SETUP_CYCLES - 1);
            state_q <= fsp_pkg::ST_SETUP;
          end else if (rd_req) begin
            rd_q    <= 1'b1;
            state_q <= fsp_pkg::ST_RD1;
          end
        end
        fsp_pkg::ST_RD1: begin
          cpu_stall  <= 1'b1;
          flash_rd   <= 1'b1;
          flash_addr <= target;
          state_q    <= fsp_pkg::ST_RD2;
        end
        fsp_pkg::ST_RD2: begin
          cpu_stall <= 1'b0;
          rd_q      <= 1'b0;
          state_q   <= fsp_pkg::ST_IDLE;
        end
        fsp_pkg::ST_SETUP: begin
          if (cnt_q != 32'h0000_0000) begin
            cnt_q <= cnt_q - 32'h0000_0001;
          end else if (free_q) begin
            cpu_stall   <= 1'b1;
            flash_erase <= 1'b1;
            flash_addr  <= {target[13:IW], {IW{1'b0}}};
            cnt_q       <= ERASE_CYCLES - 1;
            state_q     <= fsp_pkg::ST_ERASE;
          end else if (load_only_q) begin
            wr_q    <= 1'b0;
            state_q <= fsp_pkg::ST_IDLE;
          end else begin
            cpu_stall <= 1'b1;
            idx_q     <= '0;
            cnt_q     <= PROG_CYCLES - 1;
            state_q   <= fsp_pkg::ST_WALK;
          end
        end
        fsp_pkg::ST_ERASE: begin
          if (cnt_q != 32'h0000_0000) begin
            cnt_q <= cnt_q - 32'h0000_0001;
          end else begin
            cpu_stall <= 1'b0;
            wr_q      <= 1'b0;
            state_q   <= fsp_pkg::ST_IDLE;
          end
        end
        fsp_pkg::ST_WALK: begin
          // programs latch contents only; no erase is issued
          cnt_q <= cnt_q - 32'h0000_0001;
          idx_q <= idx_q + 1'b1;
          if (idx_q != '0) begin
            flash_prog  <= 1'b1;
            flash_wdata <= lat.rd_data;
            flash_addr  <= {target[13:IW], IW'(idx_q - 1'b1)};
          end
          if (idx_q == (IW+1)'(fsp_pkg::NUM_LATCHES)) begin
            state_q <= fsp_pkg::ST_WAIT;
          end
        end
        fsp_pkg::ST_WAIT: begin
          if (cnt_q != 32'h0000_0000) begin
            cnt_q <= cnt_q - 32'h0000_0001;
          end else begin
            cpu_stall <= 1'b0;
            wr_q      <= 1'b0;
            state_q   <= fsp_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= fsp_pkg::ST_IDLE;
        end
      endcase
    end
  end
endmodule // fsp_sequencer
`default_nettype wire

// >>> tb/fsp_seq_props.sv
`timescale 1ns/10ps
`default_nettype none
module fsp_seq_props #(
  parameter int unsigned ERASE_CYCLES = 40,
  parameter int unsigned PROG_CYCLES  = 40
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        cpu_stall,
  input wire logic [13:0] flash_addr,
  input wire logic        flash_rd,
  input wire logic        flash_erase,
  input wire logic        flash_prog
);
  logic [31:0] cnt_q;
  logic [1:0]  kind_q;
  logic [4:0]  idx_q;
  // length of the current stall
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cnt_q <= '0;
    else if (cpu_stall)
      cnt_q <= cnt_q + 32'h0000_0001;
    else
      cnt_q <= '0;
  end
  // kind of the last flash operation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      kind_q <= 2'h0;
    else if (flash_erase)
      kind_q <= 2'h1;
    else if (flash_prog)
      kind_q <= 2'h2;
    else if (flash_rd)
      kind_q <= 2'h0;
  end
  // latch index expected on the next program pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      idx_q <= 5'h00;
    else if (flash_prog)
      idx_q <= idx_q + 5'h01;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence steal_s;
    cpu_stall ##1 (!cpu_stall && !flash_rd);
  endsequence
  sequence burst_step_s;
    ##1 (flash_prog && $stable(flash_addr[13:5]));
  endsequence
  read_steal_a: assert property (flash_rd |-> steal_s)
    else $error("read steal is not a single stalled cycle");
  erase_len_a: assert property (
    $fell(cpu_stall) && kind_q == 2'h1 |-> cnt_q == ERASE_CYCLES)
    else $error("erase stall length wrong");
  prog_len_a: assert property (
    $fell(cpu_stall) && kind_q == 2'h2 |-> cnt_q == PROG_CYCLES)
    else $error("commit stall length wrong");
  erase_row_a: assert property (
    flash_erase |-> flash_addr[4:0] == 5'h00 && $rose(cpu_stall))
    else $error("erase not at row base or not stalling");
  prog_order_a: assert property (
    flash_prog |-> flash_addr[4:0] == idx_q)
    else $error("program pulse out of latch order");
  prog_burst_a: assert property (
    flash_prog && idx_q != 5'h1f |-> burst_step_s)
    else $error("latch block not programmed whole");
  prog_stall_a: assert property (
    flash_prog |-> cpu_stall && !flash_erase && !flash_rd)
    else $error("program outside stall or mixed");
  data_hold_a: assert property (
    $changed(hrdata) |-> $rose(hreadyout))
    else $error("read data changed outside a read");
endmodule // fsp_seq_props
bind fsp_sequencer fsp_seq_props #(
  .ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES (PROG_CYCLES)
) u_props (
  .hclk       (hclk),
  .hresetn    (hresetn),
  .hreadyout  (hreadyout),
  .hrdata     (hrdata),
  .cpu_stall  (cpu_stall),
  .flash_addr (flash_addr),
  .flash_rd   (flash_rd),
  .flash_erase(flash_erase),
  .flash_prog (flash_prog)
);
`default_nettype wire

// >>> tb/fsp_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module fsp_flash_model (
  input wire logic        hclk,
  input wire logic [13:0] flash_addr,
  input wire logic        flash_rd,
  output logic     [13:0] flash_rdata,
  input wire logic        flash_erase,
  input wire logic        flash_prog,
  input wire logic [13:0] flash_wdata
);
  logic [13:0] mem [0:16383];
  logic [13:0] last_q;
  initial begin
    for (int i = 0; i < 16384; i++)
      mem[i] = 14'(i) ^ 14'h1555;
    last_q = 14'h0000;
  end
  // released data lines show the inverse of the last word
  assign flash_rdata = flash_rd ? mem[flash_addr] : ~last_q;
  always @(posedge hclk) begin
    if (flash_rd)
      last_q <= mem[flash_addr];
    if (flash_erase)
      for (int j = 0; j < 32; j++)
        mem[{flash_addr[13:5], 5'(j)}] <= 14'h3FFF;
    if (flash_prog)
      mem[flash_addr] <= mem[flash_addr] & flash_wdata;
  end
endmodule // fsp_flash_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
  localparam int unsigned EC  = 40;
  localparam int unsigned PC  = 40;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] PGD = ONE << fsp_pkg::CTL_PGD;
  localparam logic [31:0] WEN = ONE << fsp_pkg::CTL_WEN;
  localparam logic [31:0] ER  = ONE << fsp_pkg::CTL_FREE;
  localparam logic [31:0] LWL = ONE << fsp_pkg::CTL_LOAD_ONLY;
  localparam logic [31:0] CFS = ONE << fsp_pkg::CTL_CFG_SEL;
  localparam logic [31:0] WRB = ONE << fsp_pkg::CTL_WR;
  localparam logic [31:0] RDB = ONE << fsp_pkg::CTL_RD;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, cpu_stall;
  logic        flash_rd, flash_erase, flash_prog;
  logic [31:0] haddr, hwdata, hrdata, seed, r, cv;
  logic [1:0]  htrans;
  logic [13:0] flash_addr, flash_rdata, flash_wdata, v, nd;
  logic [13:0] dat [32];
  int          error_cnt, checks, stall_n, prog_n, s0, p0;
  fsp_sequencer #(.ERASE_CYCLES(EC), .PROG_CYCLES(PC)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cpu_stall(cpu_stall), .flash_addr(flash_addr),
    .flash_rd(flash_rd), .flash_rdata(flash_rdata),
    .flash_erase(flash_erase), .flash_prog(flash_prog),
    .flash_wdata(flash_wdata));
  fsp_flash_model u_flash (
    .hclk(hclk), .flash_addr(flash_addr), .flash_rd(flash_rd),
    .flash_rdata(flash_rdata), .flash_erase(flash_erase),
    .flash_prog(flash_prog), .flash_wdata(flash_wdata));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (cpu_stall === 1'b1)
      stall_n <= stall_n + 1;
    if (flash_prog === 1'b1)
      prog_n <= prog_n + 1;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // flash contents before any erase or program
  function automatic logic [13:0] init_w(input logic [13:0] a);
    return a ^ 14'h1555;
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    q = hrdata;
    `CHK("hresp", 1'b0, hresp)
    if (n >= 50) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0000_0000, d);
  endtask
  task automatic set_a(input logic [13:0] a);
    wr(fsp_pkg::OFS_ADDR_HIGH, {26'h0, a[13:8]});
    wr(fsp_pkg::OFS_ADDR_LOW, {24'h0, a[7:0]});
  endtask
  task automatic set_d(input logic [13:0] d);
    wr(fsp_pkg::OFS_DATA_LOW, {24'h0, d[7:0]});
    wr(fsp_pkg::OFS_DATA_HIGH, {26'h0, d[13:8]});
  endtask
  // modes first, then keys, then strobe; idle bus slots follow it
  task automatic arm(input logic [31:0] c);
    wr(fsp_pkg::OFS_MEM_CTRL, c);
    wr(fsp_pkg::OFS_UNLOCK, {24'h0, fsp_pkg::UNLOCK_KEY1});
    wr(fsp_pkg::OFS_UNLOCK, {24'h0, fsp_pkg::UNLOCK_KEY2});
    wr(fsp_pkg::OFS_MEM_CTRL, c | WRB);
  endtask
  task automatic fread(input logic [13:0] a, output logic [13:0] q);
    logic [31:0] lo, hi;
    set_a(a);
    wr(fsp_pkg::OFS_MEM_CTRL, PGD | RDB);
    rd(fsp_pkg::OFS_DATA_LOW, lo);
    rd(fsp_pkg::OFS_DATA_HIGH, hi);
    q = {hi[5:0], lo[7:0]};
  endtask
  task automatic poll(input int b);
    int n;
    n = 0;
    r = 32'hFFFF_FFFF;
    while (r[b] !== 1'b0 && n < 100) begin
      rd(fsp_pkg::OFS_MEM_CTRL, r);
      n++;
    end
    `CHK("strobe clear", 1'b0, r[b])
    if (n >= 100)
      wrap_up();
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = '0;
    hwdata = '0;
    error_cnt = 0;
    checks = 0;
    stall_n = 0;
    prog_n = 0;
    seed = 32'h04ac_3b59;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(fsp_pkg::OFS_MEM_CTRL, r);
    `CHK("ctrl reset", 32'h0000_0000, r)
    rd(fsp_pkg::OFS_PROT_CFG, r);
    `CHK("prot reset", {29'h0, fsp_pkg::CPROT_RESET, fsp_pkg::WPROT_RESET}, r)
    rd(8'h1C, r);
    `CHK("unmapped", 32'h0000_0000, r)
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      wr(fsp_pkg::OFS_PROT_CFG, {29'h0, k[0], 2'b11});
      seed = xs(seed);
      s0 = stall_n;
      fread(seed[13:0], v);
      `CHK("read word", init_w(seed[13:0]), v)
      `CHK("read stall", s0 + 1, stall_n)
      rd(fsp_pkg::OFS_MEM_CTRL, r);
      `CHK("rd clear", 1'b0, r[fsp_pkg::CTL_RD])
    end
    repeat (20) @(posedge hclk);
    rd(fsp_pkg::OFS_DATA_LOW, r);
    `CHK("data hold", {24'h0, v[7:0]}, r)
    $display("test read done");
    s0 = stall_n;
    set_a(14'h0245);
    for (int i = 0; i < 5; i++) begin
      case (i)
        0: cv = PGD | ER;
        3: cv = PGD | ER | WEN | CFS;
        4: cv = ER | WEN;
        default: cv = PGD | ER | WEN;
      endcase
      wr(fsp_pkg::OFS_MEM_CTRL, cv);
      wr(fsp_pkg::OFS_UNLOCK, i == 1 ? 32'h0000_00AA : 32'h0000_0055);
      if (i == 2)
        wr(fsp_pkg::OFS_ADDR_LOW, 32'h0000_0045);
      wr(fsp_pkg::OFS_UNLOCK, i == 1 ? 32'h0000_0055 : 32'h0000_00AA);
      wr(fsp_pkg::OFS_MEM_CTRL, PGD | ER | WEN | WRB);
      rd(fsp_pkg::OFS_MEM_CTRL, r);
      `CHK("wr refused", 1'b0, r[fsp_pkg::CTL_WR])
    end
    wr(fsp_pkg::OFS_PROT_CFG, 32'h0000_0006);
    set_a(14'h0040);
    arm(PGD | ER | WEN);
    rd(fsp_pkg::OFS_MEM_CTRL, r);
    `CHK("protected", 1'b0, r[fsp_pkg::CTL_WR])
    `CHK("no stall", s0, stall_n)
    wr(fsp_pkg::OFS_PROT_CFG, 32'h0000_0007);
    $display("test refusal done");
    set_a(14'h0245);
    arm(PGD | ER | WEN);
    poll(fsp_pkg::CTL_FREE);
    `CHK("erase stall", s0 + EC, stall_n)
    fread(14'h0251, v);
    `CHK("erased", 14'h3FFF, v)
    fread(14'h0260, v);
    `CHK("next row", init_w(14'h0260), v)
    $display("test erase done");
    s0 = stall_n;
    p0 = prog_n;
    for (int i = 0; i < 32; i++) begin
      seed = xs(seed);
      dat[i] = seed[13:0];
      set_a({9'h012, 5'(i)});
      set_d(dat[i]);
      arm(i == 31 ? PGD | WEN : PGD | WEN | LWL);
      if (i == 30)
        `CHK("load only", s0 + p0, stall_n + prog_n)
    end
    poll(fsp_pkg::CTL_WR);
    `CHK("prog stall", s0 + PC, stall_n)
    `CHK("prog count", p0 + 32, prog_n)
    for (int j = 0; j < 32; j += 15) begin
      fread({9'h012, 5'(j)}, v);
      `CHK("programmed", dat[j], v)
    end
    // commit one loaded latch into an unerased row
    seed = xs(seed);
    nd = seed[13:0];
    set_a(14'h0265);
    set_d(nd);
    arm(PGD | WEN);
    poll(fsp_pkg::CTL_WR);
    `CHK("block again", p0 + 64, prog_n)
    fread(14'h0260, v);
    `CHK("latch reset", init_w(14'h0260), v)
    fread(14'h0265, v);
    `CHK("no erase", init_w(14'h0265) & nd, v)
    $display("test write done");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
